// ==== dv/tpsr_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches the link between the host and the device; host runs its default timing
module tpsr_props
    import tpsr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic phaseOneN,
    input wire logic phaseTwoN,
    input wire logic serialIn,
    input wire logic serialOut
);
    logic [15:0] lowCnt;
    logic [15:0] perCnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // low time of phase one and cycles since its last fall; zero means no fall seen yet
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lowCnt <= 16'h0000;
            perCnt <= 16'h0000;
        end else begin
            lowCnt <= phaseOneN ? 16'h0000 : lowCnt + 16'h0001;
            if ($fell(phaseOneN)) begin
                perCnt <= 16'h0001;
            end else if (perCnt != 16'h0000 && perCnt != 16'hFFFF) begin
                perCnt <= perCnt + 16'h0001; // saturates so a stall cannot wrap
            end
        end
    end

    property p_no_overlap;
        phaseOneN || phaseTwoN;
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both phases active together");

    property p_width;
        $rose(phaseOneN) |-> lowCnt >= ACTIVE_MIN_CYC && lowCnt <= ACTIVE_MAX_CYC;
    endproperty
    a_width: assert property (p_width)
        else $error("phase one low time out of range");

    property p_period;
        $fell(phaseOneN) && perCnt != 16'h0000 |-> perCnt >= PERIOD_MIN_CYC
            && perCnt <= PERIOD_MAX_CYC;
    endproperty
    a_period: assert property (p_period)
        else $error("phase period out of range");

    property p_gap_one;
        $rose(phaseOneN) |-> phaseOneN throughout (##10 $fell(phaseTwoN));
    endproperty
    a_gap_one: assert property (p_gap_one)
        else $error("phase two did not follow phase one after the dead time");

    property p_gap_two;
        $rose(phaseTwoN) |-> phaseTwoN throughout (##10 $fell(phaseOneN));
    endproperty
    a_gap_two: assert property (p_gap_two)
        else $error("phase one did not follow phase two after the dead time");

    property p_out_change;
        $changed(serialOut) |-> ($past(phaseOneN, 4) && !$past(phaseOneN, 3))
            || ($past(phaseTwoN, 4) && !$past(phaseTwoN, 3));
    endproperty
    a_out_change: assert property (p_out_change)
        else $error("serial output moved without a phase fall");

    property p_in_hold;
        $rose(phaseOneN) || $rose(phaseTwoN) |-> $stable(serialIn)[*4];
    endproperty
    a_in_hold: assert property (p_in_hold)
        else $error("serial input moved right after a phase end");

    property p_in_setup;
        $changed(serialIn) |-> ##1 (!$rose(phaseOneN) && !$rose(phaseTwoN))[*8];
    endproperty
    a_in_setup: assert property (p_in_setup)
        else $error("serial input moved too close to a phase end");

    c_one_bit: cover property ($rose(phaseOneN) && serialIn);
    c_two_bit: cover property ($rose(phaseTwoN) && serialIn);
    c_out_rise: cover property ($rose(serialOut));
endmodule
`default_nettype wire

// ==== dv/two_phase_dynamic_shift_register_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module two_phase_dynamic_shift_register_test;
    import tpsr_pkg::*;
    localparam int LEN = 8; // short register keeps the loop-back wait small
    localparam int STALL = 200;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic txBit = 1'b0;
    logic txValid = 1'b0;
    logic txReady;
    logic rxBit;
    logic rxValid;
    wire [2:0] mainFaults;
    wire [2:0] badFaults;
    logic prevOne = 1'b1;
    logic prevTwo = 1'b1;
    int fail_count = 0;
    int cmp_count = 0;
    int acc = 0;
    logic sent[$];
    logic got[$];

    tpsr_if lnk();
    tpsr_if lnkBad();

    tpsr_host tpsr_host_inst (.clk(clk), .reset(reset), .link(lnk), .txBit(txBit),
        .txValid(txValid), .txReady(txReady), .rxBit(rxBit), .rxValid(rxValid));
    tpsr_device #(.LENGTH(LEN), .STALL_CYCLES(STALL)) tpsr_device_inst (.clk(clk),
        .reset(reset), .link(lnk), .overlapFault(mainFaults[2]),
        .widthFault(mainFaults[1]), .stallFault(mainFaults[0]));
    // second device, driven by the bench so it can break the phase rules
    tpsr_device #(.LENGTH(LEN), .STALL_CYCLES(STALL)) tpsr_device_fault_inst (.clk(clk),
        .reset(reset), .link(lnkBad), .overlapFault(badFaults[2]),
        .widthFault(badFaults[1]), .stallFault(badFaults[0]));
    tpsr_props tpsr_props_inst (.clk(clk), .reset(reset), .phaseOneN(lnk.phaseOneN),
        .phaseTwoN(lnk.phaseTwoN), .serialIn(lnk.serialIn), .serialOut(lnk.serialOut));

    always #2.5 clk = ~clk;

    // log each bit left on the wire at a phase end, and each bit read back
    always @(posedge clk) begin
        if (!reset && ((lnk.phaseOneN && !prevOne) || (lnk.phaseTwoN && !prevTwo))) begin
            sent.push_back(lnk.serialIn);
        end
        if (!reset && rxValid === 1'b1) begin
            got.push_back(rxBit);
        end
        prevOne <= lnk.phaseOneN;
        prevTwo <= lnk.phaseTwoN;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic timed_out(input int n, input int lim);
        if (n >= lim) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, n, lim);
            final_report();
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // test pattern; starts with a one so it can be found in the stream
    function automatic logic pat(input int k);
        return (k % 3) != 1;
    endfunction

    task automatic check_reset();
        check({lnk.phaseOneN, lnk.phaseTwoN, lnk.serialIn, rxValid, txReady}, 5'h19);
        check({mainFaults, badFaults, lnk.serialOut}, 7'h00);
    endtask

    task automatic drive_bad(input logic one, input logic two, input int cyc);
        lnkBad.phaseOneN = one;
        lnkBad.phaseTwoN = two;
        repeat (cyc) @(negedge clk);
    endtask

    task automatic wait_bits(input logic [2:0] want, input int lim);
        int n;
        for (n = 0; n < lim && badFaults !== want; n++) @(negedge clk);
        timed_out(n, lim);
        check(badFaults, want);
    endtask

    // legal cycle, short pulse, overlap, then clocks stopped
    task automatic check_faults();
        lnkBad.serialIn = 1'b1;
        drive_bad(1'b0, 1'b1, 24);
        drive_bad(1'b1, 1'b1, 10);
        drive_bad(1'b1, 1'b0, 24);
        drive_bad(1'b1, 1'b1, 10);
        check(badFaults, 3'h0);
        drive_bad(1'b0, 1'b1, 5);
        drive_bad(1'b1, 1'b1, 2);
        wait_bits(3'h2, 20);
        drive_bad(1'b0, 1'b0, 30);
        drive_bad(1'b1, 1'b1, 2);
        wait_bits(3'h6, 20);
        repeat (100) @(negedge clk);
        check(badFaults, 3'h6);
        wait_bits(3'h7, STALL);
    endtask

    // push back to back until the fifo refuses, then offer one bit it must drop
    task automatic fill_fifo();
        int n;
        for (n = 0; n < 40 && txReady === 1'b1; n++) begin
            txBit = pat(acc);
            txValid = 1'b1;
            @(negedge clk);
            acc++;
        end
        timed_out(n, 40);
        txBit = 1'b1;
        @(negedge clk);
        txValid = 1'b0;
        check(acc >= FIFO_DEPTH && acc <= FIFO_DEPTH + 1, 1'b1);
    endtask

    task automatic check_timing();
        int n;
        int low;
        int per;
        for (n = 0; n < 200 && !(lnk.phaseOneN === 1'b0 && prevOne === 1'b1); n++) begin
            @(negedge clk);
        end
        timed_out(n, 200);
        for (low = 0; low < 3000 && lnk.phaseOneN === 1'b0; low++) @(negedge clk);
        for (per = low; per < 3000 && lnk.phaseOneN === 1'b1; per++) @(negedge clk);
        check(low, HOST_ACTIVE_CYC);
        check(per, 2 * (HOST_ACTIVE_CYC + HOST_GAP_CYC));
    endtask

    task automatic check_loopback();
        int n;
        int s;
        for (n = 0; n < 3000 && got.size() < 64; n++) @(negedge clk);
        timed_out(n, 3000);
        for (s = 0; s < 40 && sent[s] !== 1'b1; s++) begin
        end
        for (n = 0; n < acc; n++) check(sent[s + n], pat(n));
        check(sent[s + acc], 1'b0);
        for (n = 0; n + LEN < 64; n++) check(got[n + LEN], sent[n]);
        check(mainFaults, 3'h0);
    endtask

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        timed_out(1, 1);
    end

    initial begin
        lnkBad.phaseOneN = 1'b1;
        lnkBad.phaseTwoN = 1'b1;
        lnkBad.serialIn = 1'b0;
        repeat (16) @(negedge clk);
        check_reset();
        reset = 1'b0;
        check_faults();
        fill_fifo();
        check_timing();
        check_loopback();
        final_report();
    end
endmodule
`default_nettype wire

// ==== logic/tpsr_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1: driver keeps both phases running within rate
// RL2: a phase is active while held low
// RL3: master captures on one phase, slave other
// RL4: phases never overlap; dead time only holds
// RL5: input sampled at rising edge ending phase
// RL6: output changes after falling edge starting phase
// RL7: two interleaved registers, one bit per phase
// RL8: bit entered on phase one leaves on one
// RL9: bit rate is twice phase rate, bounded
// RL10: length is a parameter; no content reset (the reset here still clears the data)
module tpsr_device #(
    parameter int LENGTH = tpsr_pkg::REG_LENGTH,
    parameter int STALL_CYCLES = tpsr_pkg::PERIOD_MAX_CYC
) (
    input wire logic clk,
    input wire logic reset,
    tpsr_if.dev link,
    output logic overlapFault,
    output logic widthFault,
    output logic stallFault
);
    import tpsr_pkg::*;

    // how the block is organised:
    // - the three link pins come from another piece of logic that may run
    //   on its own timing, so every pin passes two flops before use
    // - all edge detection works on the settled (second stage) levels,
    //   which adds two clocks of latency to every shift and to the output
    // - the register is split in two interleaved halves, one per phase,
    //   each half a chain of master and slave stages
    // - a phase end moves the own half's slave chain into its master chain
    //   together with the new input bit, and copies the other half's master
    //   chain into that half's slave chain
    // - the output is refreshed at each clean phase start from the last
    //   slave stage of the matching half
    // - three sticky fault flags report broken phase timing; they only
    //   report, the shift logic keeps running as far as the rules allow
    // - there is no content reset in the real part; the reset below only
    //   clears the data so that simulation starts from known values

    // derived sizes; half of the bits live in each interleaved register
    localparam int HALF = LENGTH / 2;
    localparam int STALL_W = $clog2(STALL_CYCLES + 1);
    localparam int WID_W = $clog2(ACTIVE_MAX_CYC + 2);
    localparam logic [STALL_W-1:0] STALL_LIMIT = STALL_W'(STALL_CYCLES);
    localparam logic [WID_W-1:0] WID_MIN = WID_W'(ACTIVE_MIN_CYC);
    localparam logic [WID_W-1:0] WID_MAX = WID_W'(ACTIVE_MAX_CYC);

    // each half needs two stages for the shift slices below
    if (LENGTH < 4 || LENGTH % 2 != 0) begin : gLenCheck
        $error("tpsr_device: LENGTH must be even and at least 4");
    end
    if (STALL_CYCLES < 2) begin : gStallCheck
        $error("tpsr_device: STALL_CYCLES too small");
    end

    // pin index inside the synchroniser vectors; the order matches the
    // concatenation that fills the first stage below, so keep them together
    localparam int PIN_ONE = 2;
    localparam int PIN_TWO = 1;
    localparam int PIN_DATA = 0;

    typedef struct packed {
        logic [2:0] syncFirst;
        logic [2:0] syncSecond;
        logic [1:0] prevN;
        logic [HALF-1:0] masterOne;
        logic [HALF-1:0] slaveOne;
        logic [HALF-1:0] masterTwo;
        logic [HALF-1:0] slaveTwo;
        logic serialOut;
        logic [STALL_W-1:0] idleCnt;
        logic [WID_W-1:0] lowCnt;
        logic overlapFault;
        logic widthFault;
        logic stallFault;
    } tpsr_dev_state_t;

    tpsr_dev_state_t state;
    tpsr_dev_state_t next_state;

    logic phaseOneN;
    logic phaseTwoN;
    logic dataIn;
    logic oneActive;
    logic twoActive;
    logic riseOne;
    logic riseTwo;
    logic fallOne;
    logic fallTwo;
    logic anyEdge;
    logic transferOk;

    // settled pin levels, read only from the second stage
    assign phaseOneN = state.syncSecond[PIN_ONE];
    assign phaseTwoN = state.syncSecond[PIN_TWO];
    assign dataIn = state.syncSecond[PIN_DATA];

    // RL2: low means active
    assign oneActive = ~phaseOneN;
    assign twoActive = ~phaseTwoN;

    // edges seen against the previous settled level
    assign riseOne = ~state.prevN[1] & phaseOneN;
    assign riseTwo = ~state.prevN[0] & phaseTwoN;
    assign fallOne = state.prevN[1] & ~phaseOneN;
    assign fallTwo = state.prevN[0] & ~phaseTwoN;
    assign anyEdge = riseOne | riseTwo | fallOne | fallTwo;

    // RL4: no transfer after both phases were low together
    // an overlap would let one value race through master and slave at
    // once, so the shift is refused rather than guessed
    assign transferOk = (state.prevN != 2'h0);

    // next state of the whole block
    always_comb begin
        next_state = state;
        next_state.syncFirst = {link.phaseOneN, link.phaseTwoN, link.serialIn};
        next_state.syncSecond = state.syncFirst;
        next_state.prevN = {phaseOneN, phaseTwoN};

        // RL3: phase one fills master one
        // RL5: data taken at end of phase
        // RL7: register one takes phase one bits
        if (riseOne && transferOk) begin
            next_state.masterOne = {state.slaveOne[HALF-2:0], dataIn};
            next_state.slaveTwo = state.masterTwo;
        end

        // RL3: phase two fills master two
        // RL5: data taken at end of phase
        // RL7: register two takes phase two bits
        if (riseTwo && transferOk) begin
            next_state.masterTwo = {state.slaveTwo[HALF-2:0], dataIn};
            next_state.slaveOne = state.masterOne;
        end

        // RL6: output follows start of phase
        // RL8: phase one shows register one
        if (fallOne && !twoActive) begin
            next_state.serialOut = state.slaveOne[HALF-1];
        end else if (fallTwo && !oneActive) begin
            next_state.serialOut = state.slaveTwo[HALF-1];
        end

        // RL4: overlap seen, flag it
        if (oneActive && twoActive) begin
            next_state.overlapFault = 1'b1;
        end

        // low-time counter; checked when a phase ends
        // it saturates so a phase held low for ever still reads as too long
        // rather than wrapping back into the allowed window
        if (fallOne || fallTwo) begin
            next_state.lowCnt = WID_W'(1);
        end else if ((oneActive || twoActive) && state.lowCnt != {WID_W{1'b1}}) begin
            next_state.lowCnt = state.lowCnt + WID_W'(1);
        end
        // RL9: pulse width outside window
        if ((riseOne || riseTwo) && (state.lowCnt < WID_MIN || state.lowCnt > WID_MAX)) begin
            next_state.widthFault = 1'b1;
        end

        // RL1: stopped clocks lose contents
        // any phase edge restarts the count; the limit is a parameter so a
        // simulation can use a short one, it must exceed the edge spacing
        // RL10: contents left undefined
        if (anyEdge) begin
            next_state.idleCnt = '0;
        end else if (state.idleCnt != STALL_LIMIT) begin
            next_state.idleCnt = state.idleCnt + STALL_W'(1);
        end else begin
            next_state.stallFault = 1'b1;
        end
    end

    // single register for all state; the data halves are cleared only
    // so simulation starts known, users must not rely on their content
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.syncFirst <= 3'h7;
            state.syncSecond <= 3'h7;
            state.prevN <= 2'h3;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state register; nothing combinational
    // reaches the pins, so the far end sees clean levels only
    assign link.serialOut = state.serialOut;
    assign overlapFault = state.overlapFault;
    assign widthFault = state.widthFault;
    assign stallFault = state.stallFault;
endmodule
`default_nettype wire

// ==== logic/tpsr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// small synchronous fifo; read data comes from the storage flops
module tpsr_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = tpsr_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    import tpsr_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : gCheck
        $error("tpsr_fifo: DEPTH must be a power of two, WIDTH at least 1");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [CW-1:0] count;
    } tpsr_fifo_state_t;

    tpsr_fifo_state_t state;
    tpsr_fifo_state_t next_state;
    logic push;
    logic pop;

    // full and empty come straight from the fill count
    assign inReady = (state.count != CW'(DEPTH));
    assign outValid = (state.count != '0);
    assign outData = state.mem[state.rdPtr];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // pointer and count update
    always_comb begin
        next_state = state;
        if (push) begin
            next_state.mem[state.wrPtr] = inData;
            next_state.wrPtr = state.wrPtr + PW'(1);
        end
        if (pop) begin
            next_state.rdPtr = state.rdPtr + PW'(1);
        end
        if (push && !pop) begin
            next_state.count = state.count + CW'(1);
        end else if (pop && !push) begin
            next_state.count = state.count - CW'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

// driving end: makes both phases from clk, feeds bits from the fifo
module tpsr_host #(
    parameter int ACTIVE_CYC = tpsr_pkg::HOST_ACTIVE_CYC,
    parameter int GAP_CYC = tpsr_pkg::HOST_GAP_CYC,
    parameter int DEPTH = tpsr_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    tpsr_if.drv link,
    input wire logic txBit,
    input wire logic txValid,
    output logic txReady,
    output logic rxBit,
    output logic rxValid
);
    import tpsr_pkg::*;

    localparam int CNT_W = $clog2(ACTIVE_CYC + GAP_CYC + 1);

    // RL1: rate kept inside the window
    // RL9: bit rate bounded too
    if (ACTIVE_CYC < ACTIVE_MIN_CYC || ACTIVE_CYC > ACTIVE_MAX_CYC
        || GAP_CYC < DELAY_MIN_CYC + 3
        || 2 * (ACTIVE_CYC + GAP_CYC) < PERIOD_MIN_CYC
        || 2 * (ACTIVE_CYC + GAP_CYC) > PERIOD_MAX_CYC) begin : gCheck
        $error("tpsr_host: phase timing outside the allowed window");
    end

    typedef enum logic [1:0] {ONE_ACT, GAP_A, TWO_ACT, GAP_B} tpsr_phase_t;

    typedef struct packed {
        tpsr_phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic phaseOneN;
        logic phaseTwoN;
        logic serialIn;
        logic [1:0] sync;
        logic rxBit;
        logic rxValid;
    } tpsr_host_state_t;

    tpsr_host_state_t state;
    tpsr_host_state_t next_state;
    logic fifoBit;
    logic fifoValid;
    logic take;
    logic lastCycle;

    // the fifo drains only at phase starts, so a fast writer fills it
    tpsr_fifo #(.WIDTH(1), .DEPTH(DEPTH)) tpsr_fifo_inst (
        .clk(clk),
        .reset(reset),
        .inData(txBit),
        .inValid(txValid),
        .inReady(txReady),
        .outData(fifoBit),
        .outValid(fifoValid),
        .outReady(take)
    );

    assign lastCycle = (state.cnt == '0);
    assign take = lastCycle && (state.phase == GAP_A || state.phase == GAP_B);

    // phase sequencer; an empty fifo sends zeros, the clocks never stop
    always_comb begin
        next_state = state;
        next_state.sync = {state.sync[0], link.serialOut};
        next_state.rxValid = 1'b0;
        next_state.cnt = state.cnt - CNT_W'(1);
        if (lastCycle) begin
            case (state.phase)
                // RL4: release phase one, dead time
                // RL5: last bit is sampled now
                ONE_ACT: begin
                    next_state.phase = GAP_A;
                    next_state.cnt = CNT_W'(GAP_CYC - 1);
                    next_state.phaseOneN = 1'b1;
                    next_state.rxBit = state.sync[1];
                    next_state.rxValid = 1'b1;
                end
                // RL2: phase two goes low
                // RL7: new bit on each phase
                GAP_A: begin
                    next_state.phase = TWO_ACT;
                    next_state.cnt = CNT_W'(ACTIVE_CYC - 1);
                    next_state.phaseTwoN = 1'b0;
                    next_state.serialIn = fifoValid & fifoBit;
                end
                TWO_ACT: begin
                    next_state.phase = GAP_B;
                    next_state.cnt = CNT_W'(GAP_CYC - 1);
                    next_state.phaseTwoN = 1'b1;
                    next_state.rxBit = state.sync[1];
                    next_state.rxValid = 1'b1;
                end
                GAP_B: begin
                    next_state.phase = ONE_ACT;
                    next_state.cnt = CNT_W'(ACTIVE_CYC - 1);
                    next_state.phaseOneN = 1'b0;
                    next_state.serialIn = fifoValid & fifoBit;
                end
                default: begin
                    next_state.phase = GAP_B;
                    next_state.cnt = '0;
                    next_state.phaseOneN = 1'b1;
                    next_state.phaseTwoN = 1'b1;
                end
            endcase
        end
    end

    // both phases idle high in reset; first phase one starts on release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.phase <= GAP_B;
            state.phaseOneN <= 1'b1;
            state.phaseTwoN <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign link.phaseOneN = state.phaseOneN;
    assign link.phaseTwoN = state.phaseTwoN;
    assign link.serialIn = state.serialIn;
    assign rxBit = state.rxBit;
    assign rxValid = state.rxValid;
endmodule
`default_nettype wire

// ==== logic/tpsr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// phases are active low; the driving end makes both phases and the data
interface tpsr_if;
    logic phaseOneN;
    logic phaseTwoN;
    logic serialIn;
    logic serialOut;
    modport dev (
        input phaseOneN,
        input phaseTwoN,
        input serialIn,
        output serialOut
    );
    modport drv (
        output phaseOneN,
        output phaseTwoN,
        output serialIn,
        input serialOut
    );
endinterface
`default_nettype wire

// ==== logic/tpsr_pkg.sv ====
`default_nettype none
package tpsr_pkg;
    // clock of both ends, 200 MHz
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PS_PER_NS = 1000;
    localparam longint PS_PER_SEC_KHZ = 1000000000;
    // phase rate window in kHz
    localparam int PHASE_FREQ_MIN_KHZ = 10;
    localparam int PHASE_FREQ_MAX_KHZ = 3000;
    // bit rate is twice the phase rate
    localparam int BIT_RATE_MIN_KHZ = 2 * PHASE_FREQ_MIN_KHZ;
    localparam int BIT_RATE_MAX_KHZ = 2 * PHASE_FREQ_MAX_KHZ;
    // active-low width window and dead time between phases, in ns
    localparam int PHASE_ACTIVE_WIDTH_MIN_NS = 115;
    localparam int PHASE_ACTIVE_WIDTH_MAX_NS = 10000;
    localparam int PHASE_DELAY_MIN_NS = 10;
    // least times round up, longest times round down
    localparam int ACTIVE_MIN_CYC =
        (PHASE_ACTIVE_WIDTH_MIN_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACTIVE_MAX_CYC = PHASE_ACTIVE_WIDTH_MAX_NS * PS_PER_NS / CLK_PERIOD_PS;
    localparam int DELAY_MIN_CYC =
        (PHASE_DELAY_MIN_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PERIOD_MIN_CYC = int'((PS_PER_SEC_KHZ / PHASE_FREQ_MAX_KHZ
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int PERIOD_MAX_CYC = int'(PS_PER_SEC_KHZ / PHASE_FREQ_MIN_KHZ / CLK_PERIOD_PS);
    // default timing of the driving end: 24 + 10 + 24 + 10 = 68 cycles
    localparam int HOST_ACTIVE_CYC = 24;
    localparam int HOST_GAP_CYC = 10;
    // default register length in bits, and buffer depth
    localparam int REG_LENGTH = 256;
    localparam int FIFO_DEPTH = 16;
endpackage
`default_nettype wire
